// ===== uemr_pkg.sv
// package: constants and types for the endpoint mode responder
package uemr_pkg;
  localparam logic [7:0] ADDR_EP0_MODE = 8'h00;
  localparam logic [7:0] ADDR_EP1_MODE = 8'h04;
  localparam logic [7:0] ADDR_EP2_MODE = 8'h08;
  localparam logic [7:0] ADDR_EP0_CNT = 8'h0c;
  localparam logic [7:0] ADDR_EP1_CNT = 8'h10;
  localparam logic [7:0] ADDR_EP2_CNT = 8'h14;
  localparam int MODE_LSB = 0;
  localparam int STALL_BIT = 7;
  localparam int FLAG_SETUP_BIT = 7;
  localparam int FLAG_IN_BIT = 6;
  localparam int FLAG_OUT_BIT = 5;
  localparam int CNT_DTOG_BIT = 7;
  localparam int CNT_DVAL_BIT = 6;
  localparam logic [7:0] MODE_REG_RST = 8'h00;
  localparam logic [7:0] CNT_REG_RST = 8'h00;
  localparam logic [4:0] EP_SIZE = 5'h08;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  localparam logic [4:0] MAX_RX = EP_SIZE + CRC_BYTES;
  localparam logic [3:0] M_DIS = 4'h0;
  localparam logic [3:0] M_NAK_IO = 4'h1;
  localparam logic [3:0] M_ST_OUT = 4'h2;
  localparam logic [3:0] M_STALL_IO = 4'h3;
  localparam logic [3:0] M_IGN_IO = 4'h4;
  localparam logic [3:0] M_RSV5 = 4'h5;
  localparam logic [3:0] M_ST_IN = 4'h6;
  localparam logic [3:0] M_RSV7 = 4'h7;
  localparam logic [3:0] M_NAK_OUT = 4'h8;
  localparam logic [3:0] M_ACK_OUT = 4'h9;
  localparam logic [3:0] M_NAKO_STIN = 4'ha;
  localparam logic [3:0] M_ACKO_NAKI = 4'hb;
  localparam logic [3:0] M_NAK_IN = 4'hc;
  localparam logic [3:0] M_ACK_IN = 4'hd;
  localparam logic [3:0] M_NAKI_STO = 4'he;
  localparam logic [3:0] M_ACKI_STO = 4'hf;

  typedef enum logic [1:0] {
    PID_SETUP = 2'b00,
    PID_IN = 2'b01,
    PID_OUT = 2'b10
  } uemr_pid_t;

  typedef enum logic [2:0] {
    ACT_IGN = 3'b000,
    ACT_ACK = 3'b001,
    ACT_NAK = 3'b010,
    ACT_STALL = 3'b011,
    ACT_CHECK = 3'b100,
    ACT_TX0 = 3'b101,
    ACT_TXCNT = 3'b110
  } uemr_act_t;

  typedef enum logic [2:0] {
    RSP_ACK = 3'b001,
    RSP_NAK = 3'b010,
    RSP_STALL = 3'b011,
    RSP_DATA = 3'b100
  } uemr_rsp_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_IN_WAIT = 2'b10
  } uemr_state_t;

  // events from the packet decoder; all fields sampled when a strobe is high
  typedef struct packed {
    logic tok;
    logic dat;
    logic fin;
    uemr_pid_t pid;
    logic [1:0] ep;
    logic [4:0] cnt;
    logic crc_ok;
    logic dtog;
    logic hs_ack;
  } uemr_evt_t;

  typedef struct packed {
    logic valid;
    uemr_rsp_kind_t kind;
    logic [3:0] len;
  } uemr_rsp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uemr_bus_t;
endpackage : uemr_pkg

// ===== uemr_responder.sv
// endpoint mode responder: token reactions, auto mode changes, ep0 interlock
// Functional notes
// - reaction chosen from endpoint four-bit mode
// - mode 0001 acks SETUP, NAKs IN/OUT
// - check: ACK zero-length OUT with toggle 1
// - TX count sends count-field bytes on IN
// - status-IN modes send zero-length packet
// - ignored token gets no handshake
// - SETUP-accepting modes ACK valid SETUP
// - mode 1111 becomes 1110 after status OUT
// - accepted SETUP forces mode 0001
// - modes reset to 0000, stay disabled
// - ep0 flags record SETUP, IN, OUT
// - invalid transactions silently ignored
// - interrupt on completion or corrupted buffer
// - valid data needs count <= size+2
// - OUT endpoint ignores IN, and reverse
// - IN/OUT flags update at transaction end
// - SETUP flag updates at data phase start
// - ep0 ACK locks mode/count until read
// - mode 1001 becomes 1000 after OUT ACK
// - mode 1101 becomes 1100 after IN ACK
// - mode 1011 becomes 0001 after OUT ACK
// - bit 7 stalls ACK modes on ep1, ep2
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module uemr_responder
  import uemr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // packet decoder events
  input wire uemr_evt_t evt_i,
  // register port
  input wire uemr_bus_t bus_i,
  output logic [7:0] rd_data_o,
  // link answer and events
  output uemr_rsp_t rsp_o,
  output logic [2:0] ep_int_o,
  output logic ep0_lock_o
);

  typedef struct packed {
    uemr_state_t st;
    logic [1:0] ep;
    uemr_pid_t pid;
    logic [2:0][7:0] mode;
    logic [2:0][7:0] cnt;
    logic lock;
    uemr_rsp_t rsp;
    logic [2:0] irq;
    logic [7:0] rdata;
  } uemr_s_t;

  uemr_s_t s_q;
  uemr_s_t s_d;

  // table of reactions per mode and token
  function automatic uemr_act_t act_of(input logic [3:0] m, input uemr_pid_t p,
                                       input logic stall);
    uemr_act_t a;
    a = ACT_IGN;
    case (m)
      M_NAK_IO: a = (p == PID_SETUP) ? ACT_ACK : ACT_NAK;
      M_ST_OUT: a = (p == PID_SETUP) ? ACT_ACK : (p == PID_IN) ? ACT_STALL : ACT_CHECK;
      M_STALL_IO: a = (p == PID_SETUP) ? ACT_ACK : ACT_STALL;
      M_IGN_IO: a = (p == PID_SETUP) ? ACT_ACK : ACT_IGN;
      M_RSV5: a = (p == PID_OUT) ? ACT_ACK : ACT_IGN;
      M_ST_IN: a = (p == PID_SETUP) ? ACT_ACK : (p == PID_IN) ? ACT_TX0 : ACT_STALL;
      M_RSV7: a = (p == PID_IN) ? ACT_TXCNT : ACT_IGN;
      M_NAK_OUT: a = (p == PID_OUT) ? ACT_NAK : ACT_IGN;
      M_ACK_OUT: a = (p != PID_OUT) ? ACT_IGN : stall ? ACT_STALL : ACT_ACK;
      M_NAKO_STIN: a = (p == PID_SETUP) ? ACT_ACK : (p == PID_IN) ? ACT_TX0 : ACT_NAK;
      M_ACKO_NAKI: a = (p == PID_SETUP) ? ACT_ACK : (p == PID_IN) ? ACT_NAK : ACT_ACK;
      M_NAK_IN: a = (p == PID_IN) ? ACT_NAK : ACT_IGN;
      M_ACK_IN: a = (p != PID_IN) ? ACT_IGN : stall ? ACT_STALL : ACT_TXCNT;
      M_NAKI_STO: a = (p == PID_SETUP) ? ACT_ACK : (p == PID_IN) ? ACT_NAK : ACT_CHECK;
      M_ACKI_STO: a = (p == PID_SETUP) ? ACT_ACK : (p == PID_IN) ? ACT_TXCNT : ACT_CHECK;
      default: a = ACT_IGN;
    endcase
    return a;
  endfunction : act_of

  // mode register of an endpoint; endpoint 3 does not exist and reads disabled
  function automatic logic [7:0] mreg(input uemr_s_t s, input logic [1:0] ep);
    return (ep == 2'd3) ? MODE_REG_RST : s.mode[ep];
  endfunction : mreg

  // stall bit only exists on the non-control endpoints
  function automatic uemr_act_t act_ep(input uemr_s_t s, input logic [1:0] ep,
                                       input uemr_pid_t p);
    logic [7:0] r;
    r = mreg(s, ep);
    return act_of(r[3:0], p, (ep != 2'd0) && r[STALL_BIT]);
  endfunction : act_ep

  function automatic uemr_rsp_t mk_rsp(input uemr_rsp_kind_t k, input logic [3:0] n);
    uemr_rsp_t r;
    r.valid = 1'b1;
    r.kind = k;
    r.len = n;
    return r;
  endfunction : mk_rsp

  uemr_act_t act;
  logic [3:0] cur_mode;
  logic rx_ok;
  logic rd_ep0;

  always_comb
  begin
    s_d = s_q;
    s_d.rsp = '0;
    s_d.irq = 3'b000;
    act = ACT_IGN;
    cur_mode = 4'(mreg(s_q, s_q.ep) >> MODE_LSB);
    rx_ok = evt_i.crc_ok && (evt_i.cnt <= MAX_RX);
    rd_ep0 = bus_i.rd && ((bus_i.addr == ADDR_EP0_MODE) || (bus_i.addr == ADDR_EP0_CNT));

    // register port; reads answer in the next cycle, unmapped reads give zero
    s_d.rdata = 8'h00;
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        ADDR_EP0_MODE: s_d.rdata = s_q.mode[0];
        ADDR_EP1_MODE: s_d.rdata = s_q.mode[1];
        ADDR_EP2_MODE: s_d.rdata = s_q.mode[2];
        ADDR_EP0_CNT: s_d.rdata = s_q.cnt[0];
        ADDR_EP1_CNT: s_d.rdata = s_q.cnt[1];
        ADDR_EP2_CNT: s_d.rdata = s_q.cnt[2];
        default: s_d.rdata = 8'h00;
      endcase
    end
    // a read only unlocks once the transaction is over
    if (rd_ep0 && s_q.st == ST_IDLE)
    begin
      s_d.lock = 1'b0;
    end
    if (bus_i.wr)
    begin
      case (bus_i.addr)
        ADDR_EP0_MODE: if (!s_q.lock) s_d.mode[0] = bus_i.wdata;
        ADDR_EP1_MODE: s_d.mode[1] = bus_i.wdata;
        ADDR_EP2_MODE: s_d.mode[2] = bus_i.wdata;
        ADDR_EP0_CNT: if (!s_q.lock) s_d.cnt[0] = bus_i.wdata;
        ADDR_EP1_CNT: s_d.cnt[1] = bus_i.wdata;
        ADDR_EP2_CNT: s_d.cnt[2] = bus_i.wdata;
        default: ;
      endcase
    end

    // hardware updates come after software writes so they win a collision
    case (s_q.st)
      ST_IDLE:
      begin
        if (evt_i.tok && evt_i.ep != 2'd3)
        begin
          s_d.ep = evt_i.ep;
          s_d.pid = evt_i.pid;
          act = act_ep(s_q, evt_i.ep, evt_i.pid);
          if (evt_i.pid != PID_IN)
          begin
            s_d.st = ST_DATA;
          end
          else
          begin
            case (act)
              ACT_NAK:
              begin
                s_d.rsp = mk_rsp(RSP_NAK, 4'h0);
                s_d.irq[evt_i.ep] = 1'b1;
                if (evt_i.ep == 2'd0) s_d.mode[0][FLAG_IN_BIT] = 1'b1;
              end
              ACT_STALL:
              begin
                s_d.rsp = mk_rsp(RSP_STALL, 4'h0);
                s_d.irq[evt_i.ep] = 1'b1;
                if (evt_i.ep == 2'd0) s_d.mode[0][FLAG_IN_BIT] = 1'b1;
              end
              ACT_TX0:
              begin
                s_d.rsp = mk_rsp(RSP_DATA, 4'h0);
                s_d.st = ST_IN_WAIT;
              end
              ACT_TXCNT:
              begin
                s_d.rsp = mk_rsp(RSP_DATA, s_q.cnt[evt_i.ep][3:0]);
                s_d.st = ST_IN_WAIT;
              end
              default: ;
            endcase
          end
        end
      end
      ST_DATA:
      begin
        act = act_ep(s_q, s_q.ep, s_q.pid);
        if (evt_i.dat && s_q.pid == PID_SETUP && s_q.ep == 2'd0 && act == ACT_ACK)
        begin
          s_d.mode[0][FLAG_SETUP_BIT] = 1'b1;
        end
        if (evt_i.fin)
        begin
          s_d.st = ST_IDLE;
          if (!rx_ok)
          begin
            // silent, but a buffer that took data is flagged corrupted
            if (act == ACT_ACK)
            begin
              s_d.irq[s_q.ep] = 1'b1;
            end
          end
          else if (s_q.pid == PID_SETUP)
          begin
            if (act == ACT_ACK)
            begin
              s_d.rsp = mk_rsp(RSP_ACK, 4'h0);
              s_d.mode[s_q.ep][3:0] = M_NAK_IO;
              s_d.cnt[s_q.ep] = {evt_i.dtog, 1'b1, 2'b00, 4'(evt_i.cnt - CRC_BYTES)};
              s_d.irq[s_q.ep] = 1'b1;
              if (s_q.ep == 2'd0) s_d.lock = 1'b1;
            end
          end
          else
          begin
            case (act)
              ACT_ACK:
              begin
                s_d.rsp = mk_rsp(RSP_ACK, 4'h0);
                s_d.cnt[s_q.ep] = {evt_i.dtog, 1'b1, 2'b00, 4'(evt_i.cnt - CRC_BYTES)};
                if (cur_mode == M_ACK_OUT) s_d.mode[s_q.ep][3:0] = M_NAK_OUT;
                if (cur_mode == M_ACKO_NAKI) s_d.mode[s_q.ep][3:0] = M_NAK_IO;
                if (s_q.ep == 2'd0) s_d.lock = 1'b1;
              end
              ACT_CHECK:
              begin
                if (evt_i.cnt == CRC_BYTES && evt_i.dtog)
                begin
                  s_d.rsp = mk_rsp(RSP_ACK, 4'h0);
                  if (cur_mode == M_ACKI_STO) s_d.mode[s_q.ep][3:0] = M_NAKI_STO;
                  if (s_q.ep == 2'd0) s_d.lock = 1'b1;
                end
                else
                begin
                  s_d.rsp = mk_rsp(RSP_STALL, 4'h0);
                end
              end
              ACT_NAK: s_d.rsp = mk_rsp(RSP_NAK, 4'h0);
              ACT_STALL: s_d.rsp = mk_rsp(RSP_STALL, 4'h0);
              default: ;
            endcase
            if (act != ACT_IGN)
            begin
              s_d.irq[s_q.ep] = 1'b1;
              if (s_q.ep == 2'd0) s_d.mode[0][FLAG_OUT_BIT] = 1'b1;
            end
          end
        end
      end
      ST_IN_WAIT:
      begin
        if (evt_i.fin)
        begin
          s_d.st = ST_IDLE;
          s_d.irq[s_q.ep] = 1'b1;
          if (s_q.ep == 2'd0) s_d.mode[0][FLAG_IN_BIT] = 1'b1;
          if (evt_i.hs_ack)
          begin
            if (cur_mode == M_ACK_IN) s_d.mode[s_q.ep][3:0] = M_NAK_IN;
            if (cur_mode == M_ACKI_STO) s_d.mode[s_q.ep][3:0] = M_NAKI_STO;
            if (s_q.ep == 2'd0) s_d.lock = 1'b1;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.mode <= {3{MODE_REG_RST}};
      s_q.cnt <= {3{CNT_REG_RST}};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rdata;
  assign rsp_o = s_q.rsp;
  assign ep_int_o = s_q.irq;
  assign ep0_lock_o = s_q.lock;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence in_tok_idle;
    evt_i.tok && evt_i.pid == PID_IN && s_q.st == ST_IDLE && evt_i.ep != 2'd3;
  endsequence
  sequence out_fin_data;
    s_q.st == ST_DATA && s_q.pid == PID_OUT && evt_i.fin;
  endsequence
  sequence in_fin_wait;
    s_q.st == ST_IN_WAIT && evt_i.fin;
  endsequence

  AST_RESET_DISABLED: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    rst_i |=> s_q.mode[0][3:0] == M_DIS && s_q.mode[1][3:0] == M_DIS && !rsp_o.valid)
    else $error("mode not disabled after reset");
  AST_NAK_MODE: assert property (in_tok_idle ##0
    ((mreg(s_q, evt_i.ep) & 8'h0f) == 8'h01) |=> rsp_o.valid && rsp_o.kind == RSP_NAK)
    else $error("mode 0001 did not NAK an IN");
  AST_IGNORE_SILENT: assert property (evt_i.tok && s_q.st == ST_IDLE &&
    (mreg(s_q, evt_i.ep) & 8'h0f) == {4'h0, M_DIS} |=> !rsp_o.valid && ep_int_o == 3'b000)
    else $error("disabled endpoint answered");
  AST_TX_COUNT: assert property (in_tok_idle ##0 (evt_i.ep != 2'd0 &&
    mreg(s_q, evt_i.ep) == {4'h0, M_ACK_IN})
    |=> rsp_o.kind == RSP_DATA && rsp_o.len == s_q.cnt[s_q.ep][3:0])
    else $error("TX count length wrong");
  AST_SETUP_NAKS: assert property (rsp_o.valid && rsp_o.kind == RSP_ACK &&
    s_q.pid == PID_SETUP |-> s_q.mode[s_q.ep][3:0] == M_NAK_IO)
    else $error("SETUP ACK left mode unchanged");
  AST_EP0_LOCK: assert property (rsp_o.valid && rsp_o.kind == RSP_ACK &&
    s_q.ep == 2'd0 |-> ep0_lock_o ##1 (ep0_lock_o || $past(bus_i.rd)))
    else $error("ep0 not locked after ACK");
  AST_STATUS_OUT: assert property (out_fin_data ##0 (evt_i.crc_ok &&
    evt_i.cnt == CRC_BYTES && evt_i.dtog && cur_mode == M_ACKI_STO)
    |=> rsp_o.kind == RSP_ACK && s_q.mode[s_q.ep][3:0] == M_NAKI_STO)
    else $error("status OUT in 1111 mishandled");
  AST_BAD_CRC: assert property (s_q.st == ST_DATA && evt_i.fin &&
    !evt_i.crc_ok |=> !rsp_o.valid ##1 !rsp_o.valid)
    else $error("answered invalid packet");
  AST_OUT_ACK_MODE: assert property (out_fin_data ##0 (rx_ok &&
    cur_mode == M_ACK_OUT && s_q.ep != 2'd0 && !s_q.mode[s_q.ep][STALL_BIT])
    |=> rsp_o.kind == RSP_ACK && s_q.mode[s_q.ep][3:0] == M_NAK_OUT)
    else $error("1001 did not become 1000");
  AST_OUT_STALL_BIT: assert property (out_fin_data ##0 (rx_ok && s_q.ep != 2'd0 &&
    s_q.mode[s_q.ep][STALL_BIT] && cur_mode == M_ACK_OUT)
    |=> rsp_o.valid && rsp_o.kind == RSP_STALL && s_q.mode[s_q.ep][3:0] == M_ACK_OUT)
    else $error("stall bit did not stall an OUT");
  AST_IN_ACK_MODE: assert property (in_fin_wait ##0
    (evt_i.hs_ack && cur_mode == M_ACK_IN)
    |=> s_q.mode[s_q.ep][3:0] == M_NAK_IN && ep_int_o != 3'b000)
    else $error("1101 did not become 1100");
  AST_OUT_TO_NAK_IO: assert property (out_fin_data ##0 (rx_ok &&
    cur_mode == M_ACKO_NAKI) |=> rsp_o.kind == RSP_ACK && s_q.mode[s_q.ep][3:0] == M_NAK_IO)
    else $error("1011 did not become 0001");
  AST_STATUS_IN: assert property (in_tok_idle ##0
    ((mreg(s_q, evt_i.ep) & 8'h0f) == {4'h0, M_ST_IN} ||
    (mreg(s_q, evt_i.ep) & 8'h0f) == {4'h0, M_NAKO_STIN})
    |=> rsp_o.valid && rsp_o.kind == RSP_DATA && rsp_o.len == 4'h0)
    else $error("status IN did not send an empty packet");
  AST_CHECK_STALL: assert property (out_fin_data ##0 (rx_ok &&
    cur_mode == M_NAKI_STO && !(evt_i.cnt == CRC_BYTES && evt_i.dtog))
    |=> rsp_o.valid && rsp_o.kind == RSP_STALL)
    else $error("failed check was not stalled");
  AST_SETUP_FLAG: assert property (s_q.st == ST_DATA && evt_i.dat &&
    s_q.pid == PID_SETUP && s_q.ep == 2'd0 && act == ACT_ACK
    |=> s_q.mode[0][FLAG_SETUP_BIT])
    else $error("SETUP flag not set at data start");
  AST_LOCKED_WRITE: assert property (ep0_lock_o && bus_i.wr &&
    bus_i.addr == ADDR_EP0_CNT && s_q.st == ST_IDLE |=> $stable(s_q.cnt[0]))
    else $error("locked count register was written");
  AST_DIS_STAYS: assert property (s_q.mode[1][3:0] == M_DIS &&
    !(bus_i.wr && bus_i.addr == ADDR_EP1_MODE) |=> s_q.mode[1][3:0] == M_DIS)
    else $error("disabled endpoint left disabled mode");
  AST_IN_IGNORED: assert property (in_tok_idle ##0
    ((mreg(s_q, evt_i.ep) & 8'h0f) == {4'h0, M_ACK_OUT})
    |=> !rsp_o.valid && ep_int_o == 3'b000)
    else $error("OUT endpoint answered an IN");
  AST_LONG_IGNORED: assert property (s_q.st == ST_DATA && evt_i.fin &&
    evt_i.cnt > MAX_RX |=> !rsp_o.valid)
    else $error("oversize packet answered");
  AST_IN_FLAG: assert property (in_fin_wait ##0 (s_q.ep == 2'd0)
    |=> s_q.mode[0][FLAG_IN_BIT] && ep_int_o[0])
    else $error("IN flag not set at transaction end");
endmodule : uemr_responder

// ===== uemr_host_model.sv
// usb host model: token, data and end events toward the responder
`timescale 1ns/10ps
module uemr_host_model
  import uemr_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // answers from the responder
  input wire uemr_rsp_t rsp_i,
  input wire logic [2:0] ep_int_i,
  // events toward the responder
  output uemr_evt_t evt_o
);
  initial evt_o = '0;

  // released fields are flipped so a stale value never passes for a fresh one
  task automatic pulse(input uemr_evt_t e);
    uemr_evt_t ev;
    @(posedge ref_clk_i);
    evt_o <= e;
    ev = ~e;
    ev.tok = 1'b0;
    ev.dat = 1'b0;
    ev.fin = 1'b0;
    @(posedge ref_clk_i);
    evt_o <= ev;
  endtask : pulse

  task automatic watch(inout uemr_rsp_t r, inout logic [2:0] it);
    repeat (4)
    begin
      @(negedge ref_clk_i);
      if (rsp_i.valid === 1'b1)
        r = rsp_i;
      it = it | ep_int_i;
    end
  endtask : watch

  task automatic xfer(input uemr_pid_t p, input logic [1:0] ep, input logic [4:0] cnt,
    input logic ok, input logic tg, input int gap, output uemr_rsp_t r,
    output logic [2:0] it);
    uemr_evt_t e;
    r = '0;
    it = 3'h0;
    e = '0;
    e.pid = p;
    e.ep = ep;
    e.tok = 1'b1;
    pulse(e);
    e.tok = 1'b0;
    if (p == PID_IN)
    begin
      watch(r, it);
      if (r.kind == RSP_DATA)
      begin
        repeat (gap) @(posedge ref_clk_i);
        e.fin = 1'b1;
        e.hs_ack = ok;
        pulse(e);
        watch(r, it);
      end
    end
    else
    begin
      e.dat = 1'b1;
      pulse(e);
      e.dat = 1'b0;
      repeat (gap) @(posedge ref_clk_i);
      e.fin = 1'b1;
      e.cnt = cnt;
      e.crc_ok = ok;
      e.dtog = tg;
      pulse(e);
      watch(r, it);
    end
  endtask : xfer
endmodule : uemr_host_model

// ===== usb_endpoint_mode_responder_tb.sv
// testbench for the endpoint mode responder
`timescale 1ns/10ps
module usb_endpoint_mode_responder_tb;
  import uemr_pkg::*;
  localparam logic [7:0] RA = 8'h90;
  localparam logic [7:0] RN = 8'ha0;
  localparam logic [7:0] RS = 8'hb0;
  localparam logic [7:0] RD = 8'hc0;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  uemr_evt_t evt;
  uemr_bus_t bus = '0;
  logic [7:0] rd_data;
  uemr_rsp_t rsp;
  logic [2:0] ep_int;
  logic ep0_lock;
  int n_mismatch = 0;
  int checks_done = 0;
  uemr_rsp_t r;
  logic [2:0] it;
  logic [7:0] d;

  always #25 ref_clk_i = ~ref_clk_i;

  uemr_responder uemr_responder_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .evt_i(evt),
    .bus_i(bus), .rd_data_o(rd_data), .rsp_o(rsp), .ep_int_o(ep_int), .ep0_lock_o(ep0_lock));
  uemr_host_model uemr_host_model_inst (.ref_clk_i(ref_clk_i), .rsp_i(rsp),
    .ep_int_i(ep_int), .evt_o(evt));

  task automatic chk8(input string n, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask : chk8

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    bus <= {a, v, 2'b10};
    @(posedge ref_clk_i);
    bus <= {a, v, 2'b00};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    bus <= {a, 8'h00, 2'b01};
    @(posedge ref_clk_i);
    bus <= {a, 8'h00, 2'b00};
    @(negedge ref_clk_i);
    v = rd_data;
  endtask : rd

  task automatic tr(input string n, input uemr_pid_t p, input logic [1:0] ep,
    input logic [4:0] c, input logic ok, input logic tg, input logic [7:0] er,
    input logic [2:0] ei);
    uemr_host_model_inst.xfer(p, ep, c, ok, tg, 2, r, it);
    chk8({n, " answer"}, er, r);
    chk8({n, " int"}, {5'h00, ei}, {5'h00, it});
  endtask : tr

  task automatic t_reset;
    logic [7:0] a [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    foreach (a[i])
    begin
      rd(a[i], d);
      chk8("reset reg", 8'h00, d);
    end
    chk8("reset lock", 8'h00, {7'h00, ep0_lock});
    tr("disabled in", PID_IN, 2'd1, 5'h00, 1'b1, 1'b0, 8'h00, 3'h0);
    tr("disabled out", PID_OUT, 2'd0, 5'h02, 1'b1, 1'b1, 8'h00, 3'h0);
  endtask : t_reset

  task automatic t_setup;
    wr(ADDR_EP0_MODE, 8'h0f);
    tr("setup", PID_SETUP, 2'd0, 5'h0a, 1'b1, 1'b0, RA, 3'h1);
    chk8("lock set", 8'h01, {7'h00, ep0_lock});
    wr(ADDR_EP0_MODE, 8'h06);
    wr(ADDR_EP0_CNT, 8'h03);
    rd(ADDR_EP0_MODE, d);
    chk8("mode after setup", 8'h81, d);
    chk8("lock freed", 8'h00, {7'h00, ep0_lock});
    rd(ADDR_EP0_CNT, d);
    chk8("count after setup", 8'h48, d);
    tr("long setup", PID_SETUP, 2'd0, 5'h0b, 1'b1, 1'b0, 8'h00, 3'h1);
    tr("crc setup", PID_SETUP, 2'd0, 5'h0a, 1'b0, 1'b0, 8'h00, 3'h1);
    rd(ADDR_EP0_MODE, d);
    chk8("mode kept", 8'h01, d & 8'h0f);
  endtask : t_setup

  task automatic t_nak;
    tr("nak in", PID_IN, 2'd0, 5'h00, 1'b1, 1'b0, RN, 3'h1);
    rd(ADDR_EP0_MODE, d);
    chk8("in flag", 8'h40, d & 8'h40);
    tr("nak out", PID_OUT, 2'd0, 5'h04, 1'b1, 1'b0, RN, 3'h1);
    rd(ADDR_EP0_MODE, d);
    chk8("out flag", 8'h20, d & 8'h20);
    chk8("no lock on nak", 8'h00, {7'h00, ep0_lock});
  endtask : t_nak

  task automatic t_status;
    wr(ADDR_EP0_MODE, 8'h0f);
    tr("status out", PID_OUT, 2'd0, 5'h02, 1'b1, 1'b1, RA, 3'h1);
    rd(ADDR_EP0_MODE, d);
    chk8("mode 1110", 8'h0e, d & 8'h0f);
    tr("toggle 0", PID_OUT, 2'd0, 5'h02, 1'b1, 1'b0, RS, 3'h1);
    tr("not empty", PID_OUT, 2'd0, 5'h03, 1'b1, 1'b1, RS, 3'h1);
    wr(ADDR_EP0_MODE, 8'h06);
    tr("status in", PID_IN, 2'd0, 5'h00, 1'b1, 1'b0, RD, 3'h1);
    rd(ADDR_EP0_MODE, d);
    wr(ADDR_EP0_MODE, 8'h0a);
    tr("nak out status in", PID_IN, 2'd0, 5'h00, 1'b1, 1'b0, RD, 3'h1);
    rd(ADDR_EP0_MODE, d);
    wr(ADDR_EP0_MODE, 8'h0b);
    tr("out then nak", PID_OUT, 2'd0, 5'h04, 1'b1, 1'b0, RA, 3'h1);
    rd(ADDR_EP0_MODE, d);
    chk8("mode 0001", 8'h01, d & 8'h0f);
  endtask : t_status

  task automatic t_ep1;
    wr(ADDR_EP1_CNT, 8'h05);
    wr(ADDR_EP1_MODE, 8'h0d);
    tr("tx count", PID_IN, 2'd1, 5'h00, 1'b1, 1'b0, RD | 8'h05, 3'h2);
    rd(ADDR_EP1_MODE, d);
    chk8("mode 1100", 8'h0c, d);
    tr("nak in ep1", PID_IN, 2'd1, 5'h00, 1'b1, 1'b0, RN, 3'h2);
    tr("out to in ep", PID_OUT, 2'd1, 5'h04, 1'b1, 1'b0, 8'h00, 3'h0);
    wr(ADDR_EP1_MODE, 8'h09);
    tr("in to out ep", PID_IN, 2'd1, 5'h00, 1'b1, 1'b0, 8'h00, 3'h0);
    tr("ack out", PID_OUT, 2'd1, 5'h08, 1'b1, 1'b0, RA, 3'h2);
    rd(ADDR_EP1_MODE, d);
    chk8("mode 1000", 8'h08, d);
    wr(ADDR_EP1_MODE, 8'h89);
    tr("stall out", PID_OUT, 2'd1, 5'h04, 1'b1, 1'b0, RS, 3'h2);
    rd(ADDR_EP1_MODE, d);
    chk8("stall mode kept", 8'h89, d);
  endtask : t_ep1

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // no hang may outlive this bound
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done;
  end

  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_setup;
    t_nak;
    t_status;
    t_ep1;
    test_done;
  end
endmodule : usb_endpoint_mode_responder_tb
